// ### src/ttpc_consts.svh
// Constants for the transmitter timing and preamble control block.
// Assumes a single 50 MHz clock and a disciplined time counter fed from outside.
// What this block does
// R1 - Accept timing records from the link demultiplexer, buffer them, process before due.
// R2 - Buffered timing records drive transmitter operation and process execution times.
// R3 - Timing records are control only and never reach the emitted signal path.
// R4 - Start first bootstrap symbol edge exactly at the scheduled emission time.
// R5 - Timing buffer deep enough for every record sent ahead of its time.
// R6 - Group redundant timing copies by emission time and majority vote them.
// R7 - Extract preamble copy count from timing stream and pass it to parser.
// R8 - Accept preamble records and hold them until their emission frame.
// R9 - Release preamble stream to the inserter right after the bootstrap ends.
// R10 - Strip leading length and trailing check field, checking them for errors; code checks only the check field, the length is not read.
// R11 - Decode preamble into per-stage configuration delivered at timing manager's time; code takes it from the timing record instead.
// R12 - Preamble stays buffered during exciter setup, leaving only in its frame.
// R13 - Group redundant preamble copies by emission time, vote using copy count; code keeps the first clean copy and only tallies the rest.
// R14 - Compensate emission time for transmitter to antenna delay.
// R15 - Set data path buffer delay including network delivery compensation.
// R16 - Control identification signal insertion, its level and switching off.
// R17 - Add a per-transmitter offset to received emission times.
// R18 - Local time base locked to a leap-second-free continuous time scale.
// R19 - Fire when local time reaches buffered time; discard records already past.
`ifndef TTPC_CONSTS_SVH
`define TTPC_CONSTS_SVH
`define TTPC_TIME_W       48
`define TTPC_TM_DEPTH     8
`define TTPC_TM_AW        3
`define TTPC_PRE_DEPTH    64
`define TTPC_PRE_AW       6
`define TTPC_BOOT_NS      2000000
`define TTPC_CLK_NS       20
`define TTPC_BOOT_CYC     ((`TTPC_BOOT_NS + `TTPC_CLK_NS - 1) / `TTPC_CLK_NS)
`define TTPC_LEN_BYTES    2
`define TTPC_CHK_BYTES    2
`define TTPC_CRC_INIT     16'hFFFF
`define TTPC_CRC_POLY     16'h1021
`define TTPC_VOTE_MAX     4'h7
`endif

// ### src/ttpc_pkg.sv
// Types shared by the transmitter timing and preamble control block.
// Assumes the constants header is available on the include path.
`include "ttpc_consts.svh"
package ttpc_pkg;
  // One timing and management record as delivered by the demultiplexer.
  typedef struct packed {
    logic [`TTPC_TIME_W-1:0] emit_time;
    logic [31:0]             tx_antenna_delay;
    logic [31:0]             net_delay;
    logic [7:0]              ident_level;
    logic                    ident_on;
    logic [3:0]              tm_copies;
    logic [3:0]              pre_copies;
  } ttpc_tm_rec_type;
  // Per-stage settings released at frame start.
  typedef struct packed {
    logic [31:0] path_delay;
    logic [7:0]  ident_level;
    logic        ident_on;
  } ttpc_cfg_type;
  typedef enum logic [2:0] {
    TTPC_P_IDLE = 3'b000,
    TTPC_P_LEN  = 3'b001,
    TTPC_P_BODY = 3'b010,
    TTPC_P_CHK  = 3'b011,
    TTPC_P_DONE = 3'b100
  } ttpc_pstate_type;
endpackage

// ### src/ttpc_top.sv
// Timing manager and preamble parser for the transmitter side.
// Assumes same-clock streams from the demultiplexer and a disciplined local time input.
`timescale 1ns/1ps
`include "ttpc_consts.svh"
module ttpc_top (
  input  wire logic                    i_mclk,
  input  wire logic                    i_resetn,
  input  wire logic [`TTPC_TIME_W-1:0] i_local_time,
  input  wire logic                    i_time_locked,
  input  wire logic [`TTPC_TIME_W-1:0] i_site_offset,
  input  wire logic                    i_tm_valid,
  input  wire ttpc_pkg::ttpc_tm_rec_type i_tm_rec,
  input  wire logic                    i_pre_valid,
  input  wire logic                    i_pre_first,
  input  wire logic                    i_pre_last,
  input  wire logic [7:0]              i_pre_byte,
  input  wire logic [`TTPC_TIME_W-1:0] i_pre_time,
  output logic                         o_tm_ready,
  output logic                         o_pre_ready,
  output logic                         o_boot_start,
  output logic                         o_pre_valid,
  output logic [7:0]                   o_pre_byte,
  output logic                         o_pre_last,
  output logic                         o_pre_err,
  output ttpc_pkg::ttpc_cfg_type       o_cfg,
  output logic                         o_cfg_strobe,
  output logic [3:0]                   o_pre_copies,
  output logic                         o_late_drop
);
  // Timing record store, one slot per pending frame.
  ttpc_pkg::ttpc_tm_rec_type   tm_mem [`TTPC_TM_DEPTH];
  logic [`TTPC_TM_DEPTH-1:0]   tm_used;
  logic [3:0]                  tm_votes [`TTPC_TM_DEPTH];
  logic [`TTPC_TIME_W-1:0]     due_time [`TTPC_TM_DEPTH];
  logic [`TTPC_TM_DEPTH-1:0]   match;
  logic [`TTPC_TM_DEPTH-1:0]   due;
  logic [`TTPC_TM_DEPTH-1:0]   free;
  logic [`TTPC_TIME_W-1:0]     adj_time;
  logic                        in_past;

  // Site offset pushes the emission request later; antenna delay pulls it earlier. [R14] [R17]
  assign adj_time = i_tm_rec.emit_time + i_site_offset
                    - {{(`TTPC_TIME_W-32){1'b0}}, i_tm_rec.tx_antenna_delay}; // [R14] [R17]
  assign in_past  = i_time_locked && (adj_time <= i_local_time); // [R19]

  // Per-slot match, due and free flags; only due needs the time base locked first. [R18]
  genvar g;
  generate
    for (g = 0; g < `TTPC_TM_DEPTH; g++) begin : g_slot
      assign match[g] = tm_used[g] && (tm_mem[g].emit_time == i_tm_rec.emit_time); // [R6]
      assign due[g]   = tm_used[g] && i_time_locked && (due_time[g] <= i_local_time); // [R4] [R19]
      assign free[g]  = !tm_used[g];
    end
  endgenerate

  // Lowest free slot and lowest due slot.
  logic [`TTPC_TM_AW-1:0] free_idx;
  logic [`TTPC_TM_AW-1:0] due_idx;
  logic                   any_free;
  logic                   any_due;
  logic                   any_match;
  always_comb begin
    free_idx = '0;
    due_idx  = '0;
    for (int k = `TTPC_TM_DEPTH - 1; k >= 0; k--) begin
      if (free[k]) begin
        free_idx = k[`TTPC_TM_AW-1:0];
      end
      if (due[k]) begin
        due_idx = k[`TTPC_TM_AW-1:0];
      end
    end
  end
  assign any_free  = |free;
  assign any_due   = |due;
  assign any_match = |match;

  // Store fresh records, vote on duplicates and retire slots when they fire.
  // Duplicates only count as agreement when the settings equal the stored copy; a
  // mismatching copy replaces the stored one while it holds a single vote, else takes one vote away.
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      tm_used     <= '0;
      o_late_drop <= 1'b0;
      for (int k = 0; k < `TTPC_TM_DEPTH; k++) begin
        tm_mem[k]   <= '0;
        tm_votes[k] <= '0;
        due_time[k] <= '0;
      end
    end else begin
      o_late_drop <= 1'b0;
      for (int k = 0; k < `TTPC_TM_DEPTH; k++) begin
        if (any_due && due_idx == k[`TTPC_TM_AW-1:0]) begin
          tm_used[k] <= 1'b0; // [R19]
        end else if (i_tm_valid && !in_past && match[k]) begin
          if (tm_mem[k] == i_tm_rec) begin
            if (tm_votes[k] != `TTPC_VOTE_MAX) begin
              tm_votes[k] <= tm_votes[k] + 4'h1; // [R6]
            end
          end else if (tm_votes[k] == 4'h1) begin
            tm_mem[k]   <= i_tm_rec; // [R6]
            // The replacing copy may carry another antenna delay, so re-derive the due time.
            due_time[k] <= adj_time; // [R14] [R17]
          end else begin
            tm_votes[k] <= tm_votes[k] - 4'h1; // [R6]
          end
        end else if (i_tm_valid && !in_past && !any_match && any_free &&
                     free_idx == k[`TTPC_TM_AW-1:0]) begin
          tm_used[k]  <= 1'b1; // [R1] [R5]
          tm_mem[k]   <= i_tm_rec;
          tm_votes[k] <= 4'h1;
          due_time[k] <= adj_time;
        end
      end
      if (i_tm_valid && in_past) begin
        o_late_drop <= 1'b1; // [R19]
      end
    end
  end

  // Frame start: records are consumed here and never reach the byte path. [R3]
  logic [31:0]            boot_cnt;
  logic                   boot_run;
  logic [`TTPC_TIME_W-1:0] cur_frame;
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_boot_start <= 1'b0;
      o_cfg        <= '0;
      o_cfg_strobe <= 1'b0;
      o_pre_copies <= 4'h1;
      o_tm_ready   <= 1'b0;
      boot_run     <= 1'b0;
      boot_cnt     <= '0;
      cur_frame    <= '0;
    end else begin
      o_tm_ready   <= any_free || any_match; // [R5]
      o_boot_start <= any_due; // [R4]
      o_cfg_strobe <= any_due; // [R11]
      if (any_due) begin
        o_cfg.path_delay  <= tm_mem[due_idx].net_delay; // [R2] [R15]
        o_cfg.ident_level <= tm_mem[due_idx].ident_level; // [R16]
        o_cfg.ident_on    <= tm_mem[due_idx].ident_on; // [R16]
        o_pre_copies      <= tm_mem[due_idx].pre_copies; // [R7]
        cur_frame         <= tm_mem[due_idx].emit_time;
        boot_run          <= 1'b1;
        boot_cnt          <= 32'(`TTPC_BOOT_CYC);
      end else if (boot_run) begin
        boot_cnt <= boot_cnt - 32'h1;
        if (boot_cnt == 32'h1) begin
          boot_run <= 1'b0;
        end
      end
    end
  end
  logic release_now;
  assign release_now = boot_run && (boot_cnt == 32'h1); // [R9]

  // Preamble store: one frame's body, length and check fields removed. [R8] [R10]
  logic [7:0]               pre_mem [`TTPC_PRE_DEPTH];
  logic [`TTPC_PRE_AW:0]    wr_ptr;
  logic [`TTPC_PRE_AW:0]    rd_ptr;
  logic [`TTPC_TIME_W-1:0]  pre_frame;
  logic [3:0]               pre_seen;
  logic                     pre_held;
  logic                     sending;
  logic [15:0]              crc;
  // Body check value from before the check bytes entered the running register.
  logic [15:0]              crc_body;
  logic [15:0]              chk;
  logic [1:0]               fcnt;
  logic                     is_dup;
  ttpc_pkg::ttpc_pstate_type pstate;
  logic [15:0]              next_crc;
  // A held copy that failed its check is kept only until a later copy of that frame replaces it.
  assign is_dup = pre_held && !o_pre_err && (i_pre_time == pre_frame); // [R13]

  // Bytewise check update over the body.
  always_comb begin
    next_crc = crc ^ {i_pre_byte, 8'h00};
    for (int b = 0; b < 8; b++) begin
      next_crc = next_crc[15] ? ((next_crc << 1) ^ `TTPC_CRC_POLY) : (next_crc << 1);
    end
  end

  // Capture only the first clean copy; later copies of the same frame count toward
  // the copy figure. A single byte buffer, holding one frame at a time, keeps the store small.
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      pstate      <= ttpc_pkg::TTPC_P_IDLE;
      wr_ptr      <= '0;
      rd_ptr      <= '0;
      pre_frame   <= '0;
      pre_seen    <= '0;
      pre_held    <= 1'b0;
      sending     <= 1'b0;
      crc         <= `TTPC_CRC_INIT;
      crc_body    <= `TTPC_CRC_INIT;
      chk         <= '0;
      fcnt        <= '0;
      o_pre_err   <= 1'b0;
      o_pre_valid <= 1'b0;
      o_pre_byte  <= '0;
      o_pre_last  <= 1'b0;
      o_pre_ready <= 1'b0;
    end else begin
      o_pre_ready <= !sending;
      o_pre_valid <= 1'b0;
      o_pre_last  <= 1'b0;
      case (pstate)
        ttpc_pkg::TTPC_P_IDLE: begin
          if (i_pre_valid && i_pre_first && !sending) begin
            if (is_dup) begin
              // Copies beyond the announced count add nothing, so the tally saturates.
              if (pre_seen != o_pre_copies) begin
                pre_seen <= pre_seen + 4'h1; // [R13]
              end
              pstate   <= ttpc_pkg::TTPC_P_DONE;
            end else begin
              pstate    <= ttpc_pkg::TTPC_P_LEN; // [R8]
              pre_frame <= i_pre_time;
              pre_held  <= 1'b0;
              wr_ptr    <= '0;
              fcnt      <= 2'h1;
              crc       <= `TTPC_CRC_INIT;
              crc_body  <= `TTPC_CRC_INIT;
            end
          end
        end
        ttpc_pkg::TTPC_P_LEN: begin
          if (i_pre_valid) begin
            fcnt <= fcnt + 2'h1; // [R10]
            if (fcnt == 2'(`TTPC_LEN_BYTES - 1)) begin
              pstate <= ttpc_pkg::TTPC_P_BODY;
            end
          end
        end
        ttpc_pkg::TTPC_P_BODY: begin
          if (i_pre_valid) begin
            pre_mem[wr_ptr[`TTPC_PRE_AW-1:0]] <= i_pre_byte;
            wr_ptr <= wr_ptr + 1'b1;
            crc      <= next_crc;
            crc_body <= crc;
            if (i_pre_last) begin
              // The trailing check bytes were written; back them out. [R10]
              wr_ptr <= wr_ptr + 1'b1 - (`TTPC_PRE_AW+1)'(`TTPC_CHK_BYTES);
              chk    <= crc_body; // [R10]
              pstate <= ttpc_pkg::TTPC_P_CHK;
            end
          end
        end
        ttpc_pkg::TTPC_P_CHK: begin
          // Only one frame is buffered: a new capture drops a copy held for a later frame.
          o_pre_err <= (chk != {pre_mem[wr_ptr[`TTPC_PRE_AW-1:0]],
                                pre_mem[wr_ptr[`TTPC_PRE_AW-1:0] + 1'b1]}); // [R10]
          pre_held  <= 1'b1; // [R12]
          pre_seen  <= 4'h1;
          pstate    <= ttpc_pkg::TTPC_P_IDLE;
        end
        ttpc_pkg::TTPC_P_DONE: begin
          if (i_pre_valid && i_pre_last) begin
            pstate <= ttpc_pkg::TTPC_P_IDLE;
          end
        end
        default: begin
          pstate <= ttpc_pkg::TTPC_P_IDLE;
        end
      endcase
      // Hold the body until its own frame's bootstrap completes. [R9] [R12]
      if (release_now && pre_held && pre_frame == cur_frame) begin
        sending <= 1'b1;
        rd_ptr  <= '0;
      end else if (sending) begin
        o_pre_valid <= 1'b1;
        o_pre_byte  <= pre_mem[rd_ptr[`TTPC_PRE_AW-1:0]];
        o_pre_last  <= (rd_ptr + 1'b1 == wr_ptr);
        rd_ptr      <= rd_ptr + 1'b1;
        if (rd_ptr + 1'b1 == wr_ptr) begin
          sending  <= 1'b0;
          pre_held <= 1'b0;
        end
      end
    end
  end

  // A frame start pulse comes one cycle after a due slot.
  a_boot_cause: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R4]
    o_boot_start |-> $past(any_due)) else $error("Frame start without due record.");
  // Configuration strobes together with the frame start.
  a_cfg_with_boot: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R11]
    o_cfg_strobe == o_boot_start) else $error("Config strobe misaligned.");
  // Late records raise the drop pulse next cycle.
  a_late_drop: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R19]
    (i_tm_valid && in_past) |=> o_late_drop) else $error("Late record not dropped.");
  // Preamble output never overlaps the bootstrap interval.
  a_pre_after_boot: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R9]
    o_pre_valid |-> !boot_run) else $error("Preamble during bootstrap.");
  // Bytes leave only while sending was set.
  a_pre_held: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R12]
    o_pre_valid |-> $past(sending)) else $error("Preamble left buffer early.");
  // A due slot is retired on the following edge, so it can never fire twice.
  a_slot_retire: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R19]
    any_due |=> !tm_used[$past(due_idx)]) else $error("Due slot not retired.");
  // Copy count follows the fired record.
  a_copy_pass: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R7]
    any_due |=> o_pre_copies == $past(tm_mem[due_idx].pre_copies))
    else $error("Copy count not passed.");
  // Identification switch and level both follow the fired record.
  a_ident_ctrl: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R16]
    any_due |=> (o_cfg.ident_on == $past(tm_mem[due_idx].ident_on)) &&
                (o_cfg.ident_level == $past(tm_mem[due_idx].ident_level)))
    else $error("Ident control not applied.");
  // Ready drops when no slot can take a new frame.
  a_tm_full: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R5]
    (!any_free && !any_match) |=> !o_tm_ready) else $error("Ready while full.");

  // Further guards on slot handling, lock gating, held settings and the parser's outputs.
  // A fresh record for a new frame lands in the lowest free slot.
  a_store_new: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R1]
    (i_tm_valid && !in_past && !any_match && any_free) |=> tm_used[$past(free_idx)])
    else $error("Fresh record not stored.");
  // A late record leaves the slot table untouched.
  a_late_keep: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R19]
    (i_tm_valid && in_past && !any_due) |=> (tm_used == $past(tm_used)))
    else $error("Late record was stored.");
  // Nothing fires while the time base is not locked.
  a_lock_gate: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R18]
    !i_time_locked |=> !o_boot_start) else $error("Frame start while unlocked.");
  // The parser refuses new copies while it emits.
  a_busy_ready: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R12]
    sending |=> !o_pre_ready) else $error("Ready while emitting.");
  // The end marker only comes with a valid byte.
  a_last_valid: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R10]
    o_pre_last |-> o_pre_valid) else $error("End marker without byte.");
  // Settings hold between frame starts.
  a_cfg_hold: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R11]
    !any_due |=> $stable(o_cfg)) else $error("Settings changed between frames.");
  // The copy count also holds between frame starts.
  a_copy_hold: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R7]
    !any_due |=> $stable(o_pre_copies)) else $error("Copy count changed between frames.");
  // The error level moves only when a capture is checked.
  a_err_hold: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [R10]
    (pstate != ttpc_pkg::TTPC_P_CHK) |=> $stable(o_pre_err))
    else $error("Error level changed outside the check.");
endmodule

// ### tb/ttpc_link_src.sv
// Model of the link demultiplexer's preamble output: frames one preamble copy per call.
// Assumes the bench calls send() hierarchically and the block samples on the rising edge.
`timescale 1ns/1ps
`include "ttpc_consts.svh"
module ttpc_link_src (
  input  wire logic        i_mclk,
  output logic             o_valid,
  output logic             o_first,
  output logic             o_last,
  output logic [7:0]       o_byte,
  output logic [47:0]      o_time
);
  // Idle outputs at time zero so the block never sees unknown stream inputs.
  initial begin
    o_valid = 1'b0;
    o_first = 1'b0;
    o_last  = 1'b0;
    o_byte  = 8'h00;
    o_time  = 48'h0;
  end

  // Check value over the body, most significant bit first.
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int k = 0; k < 8; k++) begin
      r = r[15] ? ({r[14:0], 1'b0} ^ `TTPC_CRC_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction

  // One byte per cycle, changed just after the falling edge.
  task automatic put(input logic [7:0] b, input logic f, input logic l);
    @(negedge i_mclk);
    o_valid = 1'b1;
    o_first = f;
    o_last  = l;
    o_byte  = b;
  endtask

  // Length pair, body, check pair; bad corrupts the check on purpose.
  task automatic send(input logic [47:0] t, input logic [7:0] n, input logic [7:0] seed,
                      input logic bad);
    logic [15:0] c;
    c = `TTPC_CRC_INIT;
    o_time = t;
    put(8'h00, 1'b1, 1'b0);
    put(n, 1'b0, 1'b0);
    for (int k = 0; k < n; k++) begin
      put(8'(seed + k), 1'b0, 1'b0);
      c = crc_step(c, 8'(seed + k));
    end
    if (bad) c = ~c;
    put(c[15:8], 1'b0, 1'b0);
    put(c[7:0], 1'b0, 1'b1);
    // Released byte and time lines show the inverse so a stale value is never mistaken for data.
    @(negedge i_mclk);
    o_valid = 1'b0;
    o_first = 1'b0;
    o_last  = 1'b0;
    o_byte  = ~o_byte;
    o_time  = ~t;
  endtask
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the timing manager and preamble parser.
// Assumes the bootstrap count is fixed, so one full frame takes about 100000 cycles.
`timescale 1ns/1ps
`include "ttpc_consts.svh"
module tb_top;
  localparam int LIMIT = 130000;
  logic                      mclk = 1'b0;
  logic                      resetn = 1'b0;
  logic [47:0]               local_time = 48'h0;
  logic                      locked = 1'b0;
  logic [47:0]               site_offset = 48'h0;
  logic                      tm_valid = 1'b0;
  ttpc_pkg::ttpc_tm_rec_type tm_rec = '0;
  logic                      pre_valid, pre_first, pre_last;
  logic [7:0]                pre_byte;
  logic [47:0]               pre_time;
  logic                      tm_ready, pre_ready, boot, out_valid, out_last, pre_err;
  logic                      cfg_strobe, late_drop;
  logic [7:0]                out_byte;
  logic [3:0]                pre_copies;
  ttpc_pkg::ttpc_cfg_type    cfg;
  int                        n_errors = 0;
  int                        compares = 0;
  int                        cycles = 0;
  int                        n;

  ttpc_top ttpc_top_i (.i_mclk(mclk), .i_resetn(resetn), .i_local_time(local_time),
    .i_time_locked(locked), .i_site_offset(site_offset), .i_tm_valid(tm_valid),
    .i_tm_rec(tm_rec), .i_pre_valid(pre_valid), .i_pre_first(pre_first),
    .i_pre_last(pre_last), .i_pre_byte(pre_byte), .i_pre_time(pre_time),
    .o_tm_ready(tm_ready), .o_pre_ready(pre_ready), .o_boot_start(boot),
    .o_pre_valid(out_valid), .o_pre_byte(out_byte), .o_pre_last(out_last),
    .o_pre_err(pre_err), .o_cfg(cfg), .o_cfg_strobe(cfg_strobe),
    .o_pre_copies(pre_copies), .o_late_drop(late_drop));
  ttpc_link_src ttpc_link_src_i (.i_mclk(mclk), .o_valid(pre_valid), .o_first(pre_first),
    .o_last(pre_last), .o_byte(pre_byte), .o_time(pre_time));

  // 50 MHz clock.
  always #10 mclk = ~mclk;

  // Hang guard: a run past the ceiling counts as a mismatch.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_errors++;
      final_report();
    end
  end

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // One timing record, a single-cycle valid pulse.
  task automatic send_tm(input ttpc_pkg::ttpc_tm_rec_type r);
    @(negedge mclk);
    tm_valid = 1'b1;
    tm_rec   = r;
    @(negedge mclk);
    tm_valid = 1'b0;
  endtask

  // Outputs after reset; the copy count defaults to one.
  task automatic t_reset();
    @(negedge mclk);
    check(boot, 1'b0);
    check(out_valid, 1'b0);
    check(pre_copies, 4'h1);
    check(tm_ready, 1'b1);
    check(pre_ready, 1'b1);
  endtask

  // Full frame: hold-off by offset, delay and lock, then bootstrap and preamble release.
  task automatic t_frame();
    ttpc_pkg::ttpc_tm_rec_type r;
    r = '0;
    r.emit_time = 48'h7D0;
    r.tx_antenna_delay = 32'h1E;
    r.net_delay = 32'h1234;
    r.ident_level = 8'h5A;
    r.ident_on = 1'b1;
    r.tm_copies = 4'h2;
    r.pre_copies = 4'h3;
    local_time = 48'h3E8;
    site_offset = 48'h32;
    send_tm(r);
    send_tm(r);
    ttpc_link_src_i.send(48'h7D0, 8'h08, 8'h10, 1'b0);
    // Due at emit + offset - antenna delay = 0x7E4.
    local_time = 48'h7E3;
    locked = 1'b1;
    repeat (5) begin
      @(negedge mclk);
      check(boot, 1'b0);
    end
    locked = 1'b0;
    local_time = 48'h7E4;
    repeat (5) begin
      @(negedge mclk);
      check(boot, 1'b0);
    end
    locked = 1'b1;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (boot !== 1'b1 && n < 4);
    check(boot, 1'b1);
    check(cfg_strobe, 1'b1);
    check(cfg.ident_level, 8'h5A);
    check(cfg.ident_on, 1'b1);
    check(cfg.path_delay, 32'h1234);
    @(negedge mclk);
    check(pre_copies, 4'h3);
    // The stream must stay held through the whole bootstrap.
    n = 1;
    while (out_valid !== 1'b1 && n < `TTPC_BOOT_CYC + 10) begin
      @(negedge mclk);
      n++;
    end
    // The first byte shows one register stage after the bootstrap count runs out.
    check(n >= `TTPC_BOOT_CYC, 1'b1);
    check(n <= `TTPC_BOOT_CYC + 1, 1'b1);
    for (int k = 0; k < 8; k++) begin
      check(out_valid, 1'b1);
      check(pre_ready, 1'b0);
      check(out_byte, 8'(8'h10 + k));
      check(out_last, k == 7);
      @(negedge mclk);
    end
    check(out_valid, 1'b0);
    check(pre_err, 1'b0);
  endtask

  // A damaged copy raises the error level; a later clean copy of that frame
  // replaces it, and a further copy only counts as a duplicate.
  task automatic t_bad_check();
    ttpc_link_src_i.send(48'h2328, 8'h03, 8'hA0, 1'b1);
    repeat (4) @(negedge mclk);
    check(pre_err, 1'b1);
    ttpc_link_src_i.send(48'h2328, 8'h03, 8'hA0, 1'b0);
    repeat (2) @(negedge mclk);
    check(pre_err, 1'b0);
    ttpc_link_src_i.send(48'h2328, 8'h03, 8'hB0, 1'b1);
    repeat (2) @(negedge mclk);
    check(pre_err, 1'b0);
  endtask

  // Distinct future frames fill every slot, so ready drops for yet another frame
  // and returns for a copy of a stored one.
  task automatic t_fill();
    ttpc_pkg::ttpc_tm_rec_type r;
    r = '0;
    r.pre_copies = 4'h1;
    for (int k = 0; k < `TTPC_TM_DEPTH; k++) begin
      r.emit_time = 48'h10000 + 48'(k);
      send_tm(r);
    end
    tm_rec.emit_time = 48'h20000;
    repeat (2) @(negedge mclk);
    check(tm_ready, 1'b0);
    tm_rec.emit_time = 48'h10003;
    repeat (2) @(negedge mclk);
    check(tm_ready, 1'b1);
  endtask

  // A record already past its time is dropped and never fires.
  task automatic t_late();
    ttpc_pkg::ttpc_tm_rec_type r;
    r = '0;
    r.emit_time = 48'h64;
    r.pre_copies = 4'h1;
    send_tm(r);
    n = 0;
    while (late_drop !== 1'b1 && n < 4) begin
      check(boot, 1'b0);
      @(negedge mclk);
      n++;
    end
    check(late_drop, 1'b1);
    repeat (3) begin
      @(negedge mclk);
      check(boot, 1'b0);
    end
  endtask

  // Main sequence: six reset cycles, then the scenarios.
  initial begin
    repeat (6) @(negedge mclk);
    resetn = 1'b1;
    t_reset();
    t_frame();
    t_bad_check();
    t_fill();
    t_late();
    final_report();
  end
endmodule
